// ### or_move_regs.vh
// Constants for the OR, load and move instruction executor
// =============================================================================
// =============================================================================
`ifndef OR_MOVE_REGS_VH
`define OR_MOVE_REGS_VH
`define OP_OR_LIT        6'h38
`define OP_LOAD_LIT_HI   4'hc
`define OP_OR_FILE       6'h04
`define OP_MOVE_FILE     6'h08
`define OP_STORE_ACC     6'h00
`define OPC_MSB          13
`define OPC_LSB          8
`define LIT_MSB          7
`define DEST_BIT         7
`define FADDR_MSB        6
`define ACC_RESET        8'h00
`define WDATA_RESET      8'h00
`define WADDR_RESET      7'h00
`define FLAG_RESET       1'b0
`define OPC_RESET        14'h0000
`endif

// ### op_decode.v
// Opcode decoder for the five supported instructions
`include "or_move_regs.vh"
module op_decode (
    input  wire [13:0] instr,
    output reg         is_or_lit,
    output reg         is_load_lit,
    output reg         is_or_file,
    output reg         is_move_file,
    output reg         is_store_acc
);
    wire [5:0] opc;
    assign opc = instr[`OPC_MSB:`OPC_LSB];
    always @* begin
        is_or_lit    = (opc == `OP_OR_LIT);
        is_load_lit  = (opc[5:2] == `OP_LOAD_LIT_HI);
        is_or_file   = (opc == `OP_OR_FILE);
        is_move_file = (opc == `OP_MOVE_FILE);
        is_store_acc = (opc == `OP_STORE_ACC) && instr[`DEST_BIT];
    end
endmodule // op_decode

// ### or_and_move_instruction_exec.v
// Execute stage for OR, load literal, move and store instructions
`include "or_move_regs.vh"
module or_and_move_instruction_exec (
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire        instr_valid,
    input  wire [13:0] instr,
    input  wire [7:0]  file_rdata,
    input  wire        zero_in,
    output wire [6:0]  file_addr,
    output reg  [7:0]  file_wdata,
    output reg         file_we,
    output reg  [6:0]  file_waddr,
    output reg  [7:0]  acc,
    output reg         zero_we,
    output reg         zero_val,
    output reg         done
);
    // =========================================================================
    // Decode
    // =========================================================================
    wire       is_or_lit;
    wire       is_load_lit;
    wire       is_or_file;
    wire       is_move_file;
    wire       is_store_acc;
    op_decode u_dec (
        .instr        (instr),
        .is_or_lit    (is_or_lit),
        .is_load_lit  (is_load_lit),
        .is_or_file   (is_or_file),
        .is_move_file (is_move_file),
        .is_store_acc (is_store_acc)
    );

    // =========================================================================
    // Operand fields
    // =========================================================================
    wire [7:0] lit;
    wire       dest_file;
    // Read address is combinational so operand is ready in the same cycle
    assign file_addr = instr[`FADDR_MSB:0];
    assign lit       = instr[`LIT_MSB:0];
    assign dest_file = instr[`DEST_BIT];

    // =========================================================================
    // Instruction class
    // =========================================================================
    // One-hot class, bit 0 means nothing to execute
    localparam CLS_NONE      = 6'b000001;
    localparam CLS_OR_LIT    = 6'b000010;
    localparam CLS_LOAD_LIT  = 6'b000100;
    localparam CLS_OR_FILE   = 6'b001000;
    localparam CLS_MOVE_FILE = 6'b010000;
    localparam CLS_STORE_ACC = 6'b100000;
    reg  [5:0] op_class;
    always @* begin
        op_class = CLS_NONE;
        if (instr_valid) begin
            if (is_or_lit) begin
                op_class = CLS_OR_LIT;
            end else if (is_load_lit) begin
                op_class = CLS_LOAD_LIT;
            end else if (is_or_file) begin
                op_class = CLS_OR_FILE;
            end else if (is_move_file) begin
                op_class = CLS_MOVE_FILE;
            end else if (is_store_acc) begin
                op_class = CLS_STORE_ACC;
            end
        end
    end

    // =========================================================================
    // Result select and write enables
    // =========================================================================
    wire [7:0] or_lit_res;
    wire [7:0] or_file_res;
    reg  [7:0] result;
    reg        acc_we;
    reg        fwe;
    reg        zwe;
    always @* begin
        result = 8'h00;
        acc_we = 1'b0;
        fwe    = 1'b0;
        zwe    = 1'b0;
        case (op_class)
            CLS_OR_LIT: begin
                result = or_lit_res;
                acc_we = 1'b1;
                zwe    = 1'b1;
            end
            CLS_LOAD_LIT: begin
                result = lit;
                acc_we = 1'b1;
                zwe    = 1'b0;
            end
            CLS_OR_FILE: begin
                result = or_file_res;
                acc_we = ~dest_file;
                fwe    = dest_file;
                zwe    = 1'b1;
            end
            CLS_MOVE_FILE: begin
                result = file_rdata;
                acc_we = ~dest_file;
                fwe    = dest_file;
                zwe    = 1'b1;
            end
            CLS_STORE_ACC: begin
                result = acc;
                fwe    = 1'b1;
                zwe    = 1'b0;
            end
            default: begin
                result = 8'h00;
                acc_we = 1'b0;
                fwe    = 1'b0;
                zwe    = 1'b0;
            end
        endcase
    end

    // =========================================================================
    // Per-bit datapath
    // =========================================================================
    wire [8:0] zero_chain;
    wire       result_zero;
    genvar     gi;
    assign zero_chain[0] = 1'b1;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
            assign or_lit_res[gi]     = acc[gi] | lit[gi];
            assign or_file_res[gi]    = acc[gi] | file_rdata[gi];
            assign zero_chain[gi + 1] = zero_chain[gi] & ~result[gi];
        end
    endgenerate
    assign result_zero = zero_chain[8];

    // =========================================================================
    // Next values
    // =========================================================================
    reg  [7:0] acc_nxt;
    reg  [7:0] file_wdata_nxt;
    reg        file_we_nxt;
    reg  [6:0] file_waddr_nxt;
    reg        zero_we_nxt;
    reg        zero_val_nxt;
    reg        done_nxt;
    always @* begin
        acc_nxt = acc;
        if (acc_we) begin
            acc_nxt = result;
        end
        file_we_nxt    = fwe;
        file_wdata_nxt = result;
        file_waddr_nxt = file_addr;
        zero_we_nxt    = zwe;
        // Unwritten zero flag echoes its current value
        zero_val_nxt   = zwe ? result_zero : zero_in;
        done_nxt       = (op_class != CLS_NONE);
    end

    // =========================================================================
    // Registers
    // =========================================================================
    // Single-cycle commit, no skip or stall
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc <= `ACC_RESET;
        end else begin
            acc <= acc_nxt;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            file_wdata <= `WDATA_RESET;
        end else begin
            file_wdata <= file_wdata_nxt;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            file_we <= `FLAG_RESET;
        end else begin
            file_we <= file_we_nxt;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            file_waddr <= `WADDR_RESET;
        end else begin
            file_waddr <= file_waddr_nxt;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            zero_we <= `FLAG_RESET;
        end else begin
            zero_we <= zero_we_nxt;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            zero_val <= `FLAG_RESET;
        end else begin
            zero_val <= zero_val_nxt;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            done <= `FLAG_RESET;
        end else begin
            done <= done_nxt;
        end
    end
endmodule // or_and_move_instruction_exec

// ### or_move_asserts.sv
// Checker for the OR, load and move executor
module or_move_asserts (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        instr_valid,
    input wire logic        zero_in,
    input wire logic        file_we,
    input wire logic        zero_we,
    input wire logic        zero_val,
    input wire logic        done,
    input wire logic [13:0] instr,
    input wire logic [7:0]  file_rdata,
    input wire logic [7:0]  file_wdata,
    input wire logic [7:0]  acc,
    input wire logic [6:0]  file_addr,
    input wire logic [6:0]  file_waddr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire [5:0] op = instr[13:8];
    wire v  = instr_valid;
    wire fo = v && (op == 6'h04 || op == 6'h08);
    wire st = v && op == 6'h00 && instr[7];
    wire ok = fo || st || v && (op == 6'h38 || op[5:2] == 4'hc);
    sequence z_upd(logic [7:0] r); zero_we && zero_val == (r == 8'h00); endsequence
    a_or_lit: assert property (v && op == 6'h38 |=>
        acc == ($past(acc) | $past(instr[7:0])) ##0 z_upd(acc)) else $error("or lit");
    a_load_lit: assert property (v && op[5:2] == 4'hc |=>
        acc == $past(instr[7:0]) && !zero_we) else $error("load lit");
    a_or_file: assert property (v && op == 6'h04 |=>
        z_upd($past(acc) | $past(file_rdata))) else $error("or file");
    a_dest_bit: assert property (fo |=> file_we == $past(instr[7]) &&
        (file_we ? file_wdata : acc) == (($past(op[3]) ? 8'h00 : $past(acc)) | $past(file_rdata)))
        else $error("dest");
    a_move_zero: assert property (v && op == 6'h08 |=> z_upd($past(file_rdata)))
        else $error("move zero");
    a_store_acc: assert property (st |=> file_we && file_wdata == $past(acc) &&
        file_waddr == $past(instr[6:0]) && acc == $past(acc) && !zero_we) else $error("store");
    a_addr_field: assert property (file_addr == instr[6:0]) else $error("addr");
    a_done_flag: assert property (1'b1 |=> done == $past(ok)) else $error("done");
    a_zero_echo: assert property (1'b1 |=> zero_we || zero_val == $past(zero_in))
        else $error("zero echo");
endmodule // or_move_asserts
bind or_and_move_instruction_exec or_move_asserts i_chk (.*);

// ### tb_or_and_move_instruction_exec.sv
// Random bench for the OR, load and move executor
module tb_or_and_move_instruction_exec;
    timeunit 1ns; timeprecision 1ns;
    reg         sys_clk = 0, nrst = 0, instr_valid = 0, zero_in = 0;
    reg  [13:0] instr = 14'h0000;
    reg  [7:0]  file_rdata = 8'h00, r = 8'h45;
    reg  [26:0] e = 27'h0;
    wire [6:0]  file_addr, file_waddr;
    wire [7:0]  file_wdata, acc;
    wire        file_we, zero_we, zero_val, done;
    wire [33:0] got = {acc, file_we, file_we ? {file_waddr, file_wdata} : 15'h0,
                       zero_we, zero_we & zero_val, done, file_addr};
    integer     num_errors = 0, tests_run = 0, i;
    or_and_move_instruction_exec i_dut (.*);
    always #50 sys_clk = ~sys_clk;
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Next acc, write, write address and data, zero update, done
    function [26:0] model(input [13:0] w, input k, input [7:0] a, d);
        reg [7:0] q, n;
        reg       f, z;
        begin
            n = a; f = 0; z = 0; q = (w[11] ? 8'h00 : a) | d;
            if (w[13:8] == 6'h38) begin q = a | w[7:0]; n = q; z = 1; end
            else if (w[13:10] == 4'hc) n = w[7:0];
            else if (w[13:8] == 6'h04 || w[13:8] == 6'h08) begin z = 1; f = w[7]; n = f ? a : q; end
            else if (w[13:7] == 7'h01) begin q = a; f = 1; end
            else k = 0;
            model = {k ? n : a, k & f, k & f ? {w[6:0], q} : 15'h0, k & z, k & z & (q == 0), k};
        end
    endfunction
    task chk(input [33:0] x, y);
        begin
            tests_run = tests_run + 1;
            if (x !== y) begin
                num_errors = num_errors + 1;
                $display("[FAIL] outputs expected %h seen %h", x, y);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("Checks %0d errors %0d", tests_run, num_errors);
            if (num_errors == 0 && tests_run > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        for (i = 0; i < 3000; i = i + 1) begin
            @(posedge sys_clk);
            r = lfsr(lfsr(lfsr(r)));
            instr_valid <= r[7:6] != 2'h0;
            instr[13:8] <= r[2] ? (r[1] ? 6'h38 : {4'hc, r[5:4]})
                         : r[1] ? {2'h0, r[0], ~r[0], 2'h0} : {5'h0, r[0] & r[3]};
            instr[7:0] <= (i % 8) ? lfsr(r) : 8'h00;
            file_rdata <= (i % 5) ? ~r : 8'h00;
            zero_in <= r[3];
            @(negedge sys_clk);
            chk({e, instr[6:0]}, got);
            e = model(instr, instr_valid, e[26:19], file_rdata);
        end
        report_and_stop;
    end
    initial begin
        #(100 * 3500);
        num_errors = num_errors + 1;
        report_and_stop;
    end
endmodule // tb_or_and_move_instruction_exec
